/* File: src/sqf_sequencer.sv */
// four-channel supply sequencer with fault detection, latching and indication
// How it works
// - any fault drops all four supply enables at once.
// - internally found faults pull the shared fault line low immediately.
// - fault holds until all senses and request are low; the line, held low by the device itself, is not waited on.
// - externally commanded fault drives the timer pin low.
// - internally found fault raises the timer pin high.
// - origin indication stays valid until request and all senses are low.
// - a sense expected high reading low is a sequence fault.
// - precision sense judged on a sample taken about every 20 us.
// - fast low comparator flags a fault within about 1 us.
// - request withdrawn before power-on completion is a fault.
// - request raised again before power-off completion is a fault.
// - power-good timeout during power on is a fault.
// - external fault line pull makes the device hold the line low itself.
// - power-good timer restarts on each enable and resets on sense on.
// - power off steps down last channel first with delay between steps.
`timescale 1ns/1ps
`default_nettype none
module sqf_sequencer #(
  parameter int DELAY_CYC = sqf_pkg::DELAY_CYC_DEF,
  parameter int PGT_CYC = sqf_pkg::PGT_CYC_DEF,
  parameter bit PGT_USED = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic seqRequest,
  input wire logic [3:0] senseOn,
  input wire logic [3:0] senseFastLow,
  input wire logic faultLineIn,
  output logic [3:0] supplyEnables,
  output logic faultLineOut,
  output logic faultLineOe,
  output logic doneOut,
  output logic delayTimerPinHigh,
  output logic delayTimerPinOe,
  output logic faultInternal
);
  // ==========================================================
  // helpers
  function automatic logic [sqf_pkg::CNT_W-1:0] incSat(input logic [sqf_pkg::CNT_W-1:0] v);
    incSat = (v == {sqf_pkg::CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction : incSat

  function automatic logic [3:0] chMask(input logic [1:0] idx);
    chMask = 4'h1 << idx;
  endfunction : chMask

  function automatic logic isUp(input sqf_pkg::sqf_state_t s);
    isUp = (s == sqf_pkg::SQF_UP_WAIT) || (s == sqf_pkg::SQF_UP_DELAY);
  endfunction : isUp

  function automatic logic isDown(input sqf_pkg::sqf_state_t s);
    isDown = (s == sqf_pkg::SQF_DN_WAIT) || (s == sqf_pkg::SQF_DN_DELAY);
  endfunction : isDown

  // ==========================================================
  // state
  sqf_pkg::sqf_state_t state, next_state;
  logic [1:0] chan, next_chan;
  logic [sqf_pkg::CNT_W-1:0] delayCnt, next_delayCnt;
  logic [sqf_pkg::CNT_W-1:0] pgtCnt, next_pgtCnt;
  logic [sqf_pkg::CNT_W-1:0] sampleCnt, next_sampleCnt;
  logic [3:0] senseSampled, next_senseSampled;
  logic sampleFresh, next_sampleFresh;
  logic [3:0] ena, next_ena;
  logic [1:0] origin, next_origin;
  logic holdLine, next_holdLine;
  logic done, next_done;
  logic extSeen;
  logic expectHigh;
  logic [3:0] expectMask;
  logic seqFault;
  logic reqFault;
  logic pgtFault;
  logic intFault;
  logic clearOk;

  // ==========================================================
  // fault detection
  always_comb
  begin
    extSeen = !faultLineIn && !holdLine;
    expectMask = ena;
    expectHigh = isUp(state) || isDown(state) || (state == sqf_pkg::SQF_ALL_ON);
    // channels already confirmed on; the one being raised is judged by the timer
    if (state == sqf_pkg::SQF_UP_WAIT)
    begin
      expectMask = ena & ~chMask(chan);
    end
    if (state == sqf_pkg::SQF_DN_WAIT)
    begin
      expectMask = ena & ~chMask(chan);
    end
    // precision result only judged right after a fresh sample, never on a stale one
    seqFault = expectHigh && ((sampleFresh && |(expectMask & ~senseSampled)) || (|(expectMask & senseFastLow)));
    reqFault = (isUp(state) && !seqRequest) ||
               (isDown(state) && seqRequest);
    pgtFault = PGT_USED && (state == sqf_pkg::SQF_UP_WAIT) && (pgtCnt >= sqf_pkg::CNT_W'(PGT_CYC));
    intFault = seqFault || reqFault || pgtFault;
    clearOk = (senseOn == 4'h0) && !seqRequest && (faultLineIn || holdLine);
  end

  // ==========================================================
  // precision comparator sampling
  always_comb
  begin
    next_sampleCnt = (sampleCnt >= sqf_pkg::CNT_W'(sqf_pkg::SAMPLE_CYC - 1)) ? '0 : sampleCnt + 1'b1;
    next_senseSampled = (sampleCnt == '0) ? senseOn : senseSampled;
    next_sampleFresh = (sampleCnt == '0);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sampleCnt <= '0;
      senseSampled <= 4'h0;
      sampleFresh <= 1'b0;
    end
    else
    begin
      sampleCnt <= next_sampleCnt;
      senseSampled <= next_senseSampled;
      sampleFresh <= next_sampleFresh;
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    next_chan = chan;
    next_delayCnt = delayCnt;
    next_pgtCnt = pgtCnt;
    next_ena = ena;
    next_origin = origin;
    next_holdLine = holdLine;
    next_done = done;
    if (state != sqf_pkg::SQF_FAULT && (intFault || extSeen))
    begin
      next_state = sqf_pkg::SQF_FAULT;
      next_ena = sqf_pkg::ENA_RESET;
      next_holdLine = 1'b1;
      next_origin = intFault ? sqf_pkg::IND_INT : sqf_pkg::IND_EXT;
      next_done = 1'b0;
    end
    else
    begin
      case (state)
        sqf_pkg::SQF_OFF:
        begin
          next_done = 1'b0;
          if (seqRequest)
          begin
            next_chan = 2'h0;
            next_ena = chMask(2'h0);
            next_pgtCnt = '0;
            next_state = sqf_pkg::SQF_UP_WAIT;
          end
        end
        sqf_pkg::SQF_UP_WAIT:
        begin
          next_pgtCnt = incSat(pgtCnt);
          if (senseOn[chan])
          begin
            next_pgtCnt = '0;
            next_delayCnt = '0;
            if (chan == 2'h3)
            begin
              next_state = sqf_pkg::SQF_ALL_ON;
              next_done = 1'b1;
            end
            else
            begin
              next_state = sqf_pkg::SQF_UP_DELAY;
            end
          end
        end
        sqf_pkg::SQF_UP_DELAY:
        begin
          next_delayCnt = incSat(delayCnt);
          if (delayCnt >= sqf_pkg::CNT_W'(DELAY_CYC - 1))
          begin
            next_chan = chan + 2'h1;
            next_ena = ena | chMask(chan + 2'h1);
            next_pgtCnt = '0;
            next_state = sqf_pkg::SQF_UP_WAIT;
          end
        end
        sqf_pkg::SQF_ALL_ON:
        begin
          if (!seqRequest)
          begin
            next_chan = 2'h3;
            next_ena = ena & ~chMask(2'h3);
            next_state = sqf_pkg::SQF_DN_WAIT;
          end
        end
        sqf_pkg::SQF_DN_WAIT:
        begin
          if (!senseOn[chan])
          begin
            next_delayCnt = '0;
            if (chan == 2'h0)
            begin
              next_state = sqf_pkg::SQF_OFF;
              next_done = 1'b0;
            end
            else
            begin
              next_state = sqf_pkg::SQF_DN_DELAY;
            end
          end
        end
        sqf_pkg::SQF_DN_DELAY:
        begin
          next_delayCnt = incSat(delayCnt);
          if (delayCnt >= sqf_pkg::CNT_W'(DELAY_CYC - 1))
          begin
            next_chan = chan - 2'h1;
            next_ena = ena & ~chMask(chan - 2'h1);
            next_state = sqf_pkg::SQF_DN_WAIT;
          end
        end
        sqf_pkg::SQF_FAULT:
        begin
          next_ena = sqf_pkg::ENA_RESET;
          if (clearOk)
          begin
            next_state = sqf_pkg::SQF_OFF;
            next_holdLine = 1'b0;
            next_origin = sqf_pkg::IND_IDLE;
          end
        end
        default:
        begin
          next_state = sqf_pkg::SQF_FAULT;
          next_ena = sqf_pkg::ENA_RESET;
          next_holdLine = 1'b1;
          next_origin = sqf_pkg::IND_INT;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= sqf_pkg::SQF_OFF;
      chan <= 2'h0;
      delayCnt <= '0;
      pgtCnt <= '0;
      ena <= sqf_pkg::ENA_RESET;
      origin <= sqf_pkg::IND_IDLE;
      holdLine <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      chan <= next_chan;
      delayCnt <= next_delayCnt;
      pgtCnt <= next_pgtCnt;
      ena <= next_ena;
      origin <= next_origin;
      holdLine <= next_holdLine;
      done <= next_done;
    end
  end

  // ==========================================================
  // outputs, each a flip-flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      supplyEnables <= 4'h0;
      faultLineOut <= 1'b0;
      faultLineOe <= 1'b0;
      doneOut <= 1'b0;
      delayTimerPinHigh <= 1'b0;
      delayTimerPinOe <= 1'b0;
      faultInternal <= 1'b0;
    end
    else
    begin
      supplyEnables <= next_ena;
      faultLineOut <= 1'b0;
      faultLineOe <= next_holdLine;
      doneOut <= next_done;
      delayTimerPinHigh <= (next_origin == sqf_pkg::IND_INT);
      delayTimerPinOe <= (next_origin != sqf_pkg::IND_IDLE);
      faultInternal <= (next_origin == sqf_pkg::IND_INT);
    end
  end
endmodule : sqf_sequencer
`default_nettype wire

/* File: src/sqf_pkg.sv */
// constants and types shared by the supply sequencer fault logic
package sqf_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_HZ = 40000000;
  localparam int SAMPLE_US = 20;
  localparam int SAMPLE_CYC = (SAMPLE_US * CLK_HZ + 999999) / 1000000;
  localparam int FAST_US = 1;
  localparam int FAST_CYC = (FAST_US * CLK_HZ) / 1000000;
  localparam int DELAY_CYC_DEF = 400;
  localparam int PGT_CYC_DEF = 4000;
  localparam int CNT_W = 24;
  localparam logic [3:0] ENA_RESET = 4'h0;
  localparam logic [1:0] IND_IDLE = 2'h0;
  localparam logic [1:0] IND_INT = 2'h1;
  localparam logic [1:0] IND_EXT = 2'h2;
  typedef enum logic [2:0]
  {
    SQF_OFF = 3'h0,
    SQF_UP_WAIT = 3'h1,
    SQF_UP_DELAY = 3'h3,
    SQF_ALL_ON = 3'h2,
    SQF_DN_DELAY = 3'h6,
    SQF_DN_WAIT = 3'h7,
    SQF_FAULT = 3'h5
  } sqf_state_t;
endpackage : sqf_pkg

/* File: testbench/sqf_checker.sv */
// port assertions for the supply sequencer fault logic
`timescale 1ns/1ps
`default_nettype none
module sqf_checker #(
  parameter int DELAY_CYC = 4,
  parameter int PGT_CYC = 20,
  parameter bit PGT_USED = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic seqRequest,
  input wire logic [3:0] senseOn,
  input wire logic [3:0] senseFastLow,
  input wire logic faultLineIn,
  input wire logic [3:0] supplyEnables,
  input wire logic faultLineOut,
  input wire logic faultLineOe,
  input wire logic doneOut,
  input wire logic delayTimerPinHigh,
  input wire logic delayTimerPinOe,
  input wire logic faultInternal
);
  // =====
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  fault_drop_a: assert property (faultLineOe |-> supplyEnables == 4'h0) else $error("enables up in fault");
  fast_fault_a: assert property ((doneOut && |(supplyEnables & senseFastLow)) |=>
    (supplyEnables == 4'h0 && faultLineOe)) else $error("fast low missed");
  origin_ind_a: assert property (($rose(delayTimerPinOe) && $past(faultLineIn)) |->
    (delayTimerPinHigh && faultInternal)) else $error("internal origin not shown");
  ind_stable_a: assert property ((delayTimerPinOe && $past(delayTimerPinOe)) |->
    $stable(delayTimerPinHigh)) else $error("origin changed while latched");
  line_low_a: assert property (faultLineOut == 1'b0) else $error("fault line value not low");
  ext_fault_a: assert property (($fell(faultLineIn) && !faultLineOe && !delayTimerPinOe) |=>
    (faultLineOe && delayTimerPinOe && !delayTimerPinHigh)) else $error("external fault missed");
  fault_hold_a: assert property ((delayTimerPinOe && (seqRequest || senseOn != 4'h0)) |=>
    delayTimerPinOe) else $error("fault released early");
  fault_clear_a: assert property ((delayTimerPinOe && !seqRequest && senseOn == 4'h0 &&
    (faultLineIn || faultLineOe)) |=> !delayTimerPinOe) else $error("fault not cleared");
  req_drop_a: assert property (($fell(seqRequest) && !doneOut && supplyEnables != 4'h0 &&
    !delayTimerPinOe) |=> (faultLineOe && faultInternal)) else $error("early drop missed");
  req_rise_a: assert property (($rose(seqRequest) && doneOut && !delayTimerPinOe) |=>
    (faultLineOe && supplyEnables == 4'h0)) else $error("early rise missed");
  down_order_a: assert property (($fell(seqRequest) && doneOut && supplyEnables == 4'hF) |=>
    supplyEnables == 4'h7) else $error("power off order");
  cover property (doneOut);
  cover property (delayTimerPinOe && faultInternal);
  cover property (delayTimerPinOe && !delayTimerPinHigh);
endmodule : sqf_checker
bind sqf_sequencer sqf_checker #(.DELAY_CYC(DELAY_CYC), .PGT_CYC(PGT_CYC), .PGT_USED(PGT_USED)) chk_u (
  .clk(clk), .rst(rst), .seqRequest(seqRequest), .senseOn(senseOn), .senseFastLow(senseFastLow),
  .faultLineIn(faultLineIn), .supplyEnables(supplyEnables), .faultLineOut(faultLineOut), .faultLineOe(faultLineOe),
  .doneOut(doneOut), .delayTimerPinHigh(delayTimerPinHigh), .delayTimerPinOe(delayTimerPinOe),
  .faultInternal(faultInternal)
);
`default_nettype wire

/* File: testbench/sqf_supply_model.sv */
// sensed supplies facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sqf_supply_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] supplyEnables,
  input wire logic [3:0] dead,
  input wire logic [3:0] sag,
  output logic [3:0] senseOn,
  output logic [3:0] senseFastLow
);
  // =====
  // sense follows enable a cycle late
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      senseOn <= 4'h0;
      senseFastLow <= 4'hF;
    end
    else
    begin
      senseOn <= supplyEnables & ~dead & ~sag;
      senseFastLow <= ~(supplyEnables & ~dead);
    end
  end
endmodule : sqf_supply_model
`default_nettype wire

/* File: testbench/sqf_sequencer_tb.sv */
// self-checking bench for the supply sequencer fault logic
`timescale 1ns/1ps
`default_nettype none
module sqf_sequencer_tb;
  logic clk, rst, seqRequest, extPull, faultLineOut, faultLineOe, doneOut;
  logic delayTimerPinHigh, delayTimerPinOe, faultInternal;
  logic [3:0] senseOn, senseFastLow, supplyEnables, dead, sag;
  wire logic faultLineIn;
  int numErrors = 0;
  int comparisons = 0;
  int n;
  assign faultLineIn = ~(faultLineOe | extPull);
  sqf_sequencer #(.DELAY_CYC(4), .PGT_CYC(20)) dut_u (
    .clk(clk), .rst(rst), .seqRequest(seqRequest), .senseOn(senseOn), .senseFastLow(senseFastLow),
    .faultLineIn(faultLineIn), .supplyEnables(supplyEnables), .faultLineOut(faultLineOut),
    .faultLineOe(faultLineOe), .doneOut(doneOut), .delayTimerPinHigh(delayTimerPinHigh),
    .delayTimerPinOe(delayTimerPinOe), .faultInternal(faultInternal)
  );
  sqf_supply_model sup_u (
    .clk(clk), .rst(rst), .supplyEnables(supplyEnables), .dead(dead), .sag(sag),
    .senseOn(senseOn), .senseFastLow(senseFastLow)
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // =====
  // helpers
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_fault(input int lim);
    for (n = 0; n < lim && faultLineOe !== 1'b1; n++) step(1);
  endtask : wait_fault
  task automatic power_on;
    seqRequest = 1'b1;
    for (n = 0; n < 200 && doneOut !== 1'b1; n++) step(1);
    check(supplyEnables, 4'hF);
  endtask : power_on
  task automatic clear_fault;
    seqRequest = 1'b0;
    dead = 4'h0;
    sag = 4'h0;
    extPull = 1'b0;
    step(4);
    check({faultLineOe, delayTimerPinOe, supplyEnables[1:0]}, 4'h0);
  endtask : clear_fault
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // =====
  // scenarios
  task automatic t_cycle;
    power_on();
    seqRequest = 1'b0;
    step(1);
    check(supplyEnables, 4'h7);
    for (n = 0; n < 200 && doneOut !== 1'b0; n++) step(1);
    check({doneOut, faultLineOe, supplyEnables[1:0]}, 4'h0);
    $display("power cycle test ended");
  endtask : t_cycle
  task automatic t_fast;
    power_on();
    dead = 4'h2;
    step(2);
    check({faultLineOe, delayTimerPinOe, delayTimerPinHigh, |supplyEnables}, 4'hE);
    check({3'h0, faultLineOut}, 4'h0);
    step(5);
    check({faultLineOe, delayTimerPinOe, delayTimerPinHigh, |supplyEnables}, 4'hE);
    clear_fault();
    $display("fast fault test ended");
  endtask : t_fast
  task automatic t_sample;
    power_on();
    sag = 4'h4;
    wait_fault(900);
    check({faultLineOe, faultInternal, supplyEnables[1:0]}, 4'hC);
    clear_fault();
    $display("sampled fault test ended");
  endtask : t_sample
  task automatic t_ext;
    power_on();
    extPull = 1'b1;
    step(1);
    check({faultLineOe, delayTimerPinOe, delayTimerPinHigh, |supplyEnables}, 4'hC);
    extPull = 1'b0;
    step(3);
    check({faultLineOe, delayTimerPinOe, delayTimerPinHigh, |supplyEnables}, 4'hC);
    clear_fault();
    $display("external fault test ended");
  endtask : t_ext
  task automatic t_req;
    seqRequest = 1'b1;
    for (n = 0; n < 100 && supplyEnables !== 4'h3; n++) step(1);
    seqRequest = 1'b0;
    step(1);
    check({faultLineOe, faultInternal, |supplyEnables}, 4'h6);
    clear_fault();
    power_on();
    seqRequest = 1'b0;
    step(1);
    seqRequest = 1'b1;
    step(1);
    check({faultLineOe, faultInternal, |supplyEnables}, 4'h6);
    clear_fault();
    $display("request error test ended");
  endtask : t_req
  task automatic t_pgt;
    dead = 4'h1;
    seqRequest = 1'b1;
    wait_fault(100);
    check({faultLineOe, faultInternal, supplyEnables[1:0]}, 4'hC);
    clear_fault();
    $display("timeout test ended");
  endtask : t_pgt
  initial
  begin
    rst = 1'b1;
    seqRequest = 1'b0;
    extPull = 1'b0;
    dead = 4'h0;
    sag = 4'h0;
    step(8);
    rst = 1'b0;
    t_cycle();
    t_fast();
    t_sample();
    t_ext();
    t_req();
    t_pgt();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    numErrors++;
    stop_test();
  end
endmodule : sqf_sequencer_tb
`default_nettype wire
